// *** alarm_output.sv ***
// Purpose: One alarm channel: contact polarity, on/off delays, loop stall detection
// Assumes: Loop inputs synchronous to CLK; events are one-cycle pulses
// Notes:   Registers over AXI4-Lite; second ticks from a clock divider
// Overview of operation
// [R1] Open-when-idle polarity: contact open while idle, closed while alarm active.
// [R2] Closed-when-idle polarity: contact closed while idle, open while alarm active.
// [R3] Indicator lit while alarm active, dark otherwise, whatever the polarity.
// [R4] While a delay runs, output holds and indicator flashes each half second.
// [R5] On-delay elapses, condition rechecked, output set only if still true.
// [R6] Off-delay elapses, condition rechecked, output cleared only if still clear.
// [R7] On and off delays take 0 to 3600 seconds, default zero.
// [R8] Heating: full output without rise, or zero without fall, raises stall.
// [R9] Cooling: zero output without rise, or full without fall, raises stall.
// [R10] Tuning, manual, stop or ramp suppress stall checks unless input fault.
// [R11] Init, mode change or zero time/band restart timer and clear stall.
// [R12] Correction or set value change restarts timer, keeps stall state.
// [R13] Output change, stop or tune start restart timer; standard mode clears.
// [R14] Sensor break or input range fault forces stall alarm on.
// [R15] Alarm reset restarts the stall watch start time.
// [R16] Stall detection works only when the channel selects stall mode.
// [R17] Tune completion stores twice the integral time as watch time.
// [R18] Watch time 0 to 9999 s, default 0; auto value clamped 20..9999.
// [R19] Band up to 999.9, default 2.0; auto band clamped 2.0..100.0.
// [R20] Stored time and band kept unless input type, retune or manual set.
// [R21] Output moving off a limit keeps restarting the watch timer.
// [R22] Standard mode: the expected rise or fall beyond band (per R8/R9) in a full watch clears the alarm.
// [R23] Counters step on a divided one-second tick; flash uses half second.
module alarm_output
    import alarm_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire loop_status_t LOOP,
    input  wire loop_event_t  EVENTS,
    input  wire logic         ALARM_RESET,
    output logic              CONTACT,
    output logic              INDICATOR,
    input  wire logic [7:0]   AWADDR,
    input  wire logic         AWVALID,
    output logic              AWREADY,
    input  wire logic [31:0]  WDATA,
    input  wire logic [3:0]   WSTRB,
    input  wire logic         WVALID,
    output logic              WREADY,
    output logic [1:0]        BRESP,
    output logic              BVALID,
    input  wire logic         BREADY,
    input  wire logic [7:0]   ARADDR,
    input  wire logic         ARVALID,
    output logic              ARREADY,
    output logic [31:0]       RDATA,
    output logic [1:0]        RRESP,
    output logic              RVALID,
    input  wire logic         RREADY
);

    function automatic logic [13:0] clamp(input logic [14:0] v, input logic [13:0] lo,
                                          input logic [13:0] hi);
        if (v < {1'b0, lo}) return lo;
        if (v > {1'b0, hi}) return hi;
        return v[13:0];
    endfunction

    function automatic logic [11:0] sat_delay(input logic [15:0] v);
        return (v > {4'h0, DELAY_MAX}) ? DELAY_MAX : v[11:0];
    endfunction

    logic [26:0]   div_count;
    logic          tick_sec;
    logic [25:0]   half_count;
    logic          flash;
    logic [5:0]    ctrl;
    logic [11:0]   on_delay;
    logic [11:0]   off_delay;
    logic [13:0]   watch_time;
    logic [13:0]   stall_detect_band;
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          do_write;
    logic          wr_ok;
    delay_state_t  dstate;
    logic [11:0]   delay_count;
    logic          alarm_active;
    logic          loop_stall_alarm;
    logic [13:0]   watch_count;
    logic [13:0]   pv_start;
    logic [9:0]    out_prev;
    logic          running_prev;
    logic          tune_prev;
    logic          cool_prev;
    logic          trigger;
    logic          at_full;
    logic          at_zero;
    logic          suppress;
    logic          input_fault;
    logic          zero_cfg;
    logic          restart_clear;
    logic          restart_keep;
    logic          restart_std;
    logic          rose;
    logic          fell;
    logic [14:0]   tuned_twice;
    logic          manual_watch;
    logic          manual_band;

    // Second tick and half-second flash
    always_ff @(posedge CLK) begin
        if (RST || div_count == 27'(SEC_CYCLES - 1)) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 27'h1;
        end
    end
    assign tick_sec = (div_count == 27'(SEC_CYCLES - 1)); // R23

    always_ff @(posedge CLK) begin
        if (RST) begin
            half_count <= '0;
            flash      <= 1'b0;
        end else if (half_count == 26'(HALF_CYCLES - 1)) begin
            half_count <= '0;
            flash      <= ~flash; // R23
        end else begin
            half_count <= half_count + 26'h1;
        end
    end

    // AXI4-Lite write side
    assign AWREADY  = !aw_held && !BVALID;
    assign WREADY   = !w_held && !BVALID;
    assign do_write = aw_held && w_held && !BVALID;
    assign wr_ok    = aw_addr == ADDR_CTRL || aw_addr == ADDR_DELAY ||
                      aw_addr == ADDR_WATCH || aw_addr == ADDR_BAND;
    assign manual_watch = do_write && aw_addr == ADDR_WATCH && w_strb[0];
    assign manual_band  = do_write && aw_addr == ADDR_BAND && w_strb[0];

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            BVALID  <= 1'b0;
            BRESP   <= RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                BVALID  <= 1'b1;
                BRESP   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl      <= '0;
            on_delay  <= '0;
            off_delay <= '0;
        end else if (do_write && aw_addr == ADDR_CTRL && w_strb[0]) begin
            ctrl <= {1'b0, w_data[4:0]};
        end else if (do_write && aw_addr == ADDR_DELAY) begin
            if (w_strb[1:0] == 2'h3) begin
                on_delay <= sat_delay(w_data[15:0]); // R7
            end
            if (w_strb[3:2] == 2'h3) begin
                off_delay <= sat_delay(w_data[31:16]); // R7
            end
        end else begin
            ctrl[CTRL_INIT] <= 1'b0;
        end
    end

    assign tuned_twice = {EVENTS.tuned_integral, 1'b0};

    always_ff @(posedge CLK) begin
        if (RST || EVENTS.input_type_change) begin
            watch_time        <= '0; // R20
            stall_detect_band <= BAND_RESET; // R19
        end else if (EVENTS.tune_done) begin
            watch_time        <= clamp(tuned_twice, WATCH_AUTO_MIN, WATCH_MAX); // R17 R18
            stall_detect_band <= clamp({1'b0, EVENTS.tuned_band}, BAND_AUTO_MIN,
                                       BAND_AUTO_MAX); // R19
        end else begin
            if (manual_watch) begin
                watch_time <= clamp({1'b0, w_data[13:0]}, 14'h0000, WATCH_MAX); // R18 R20
            end
            if (manual_band) begin
                stall_detect_band <= clamp({1'b0, w_data[13:0]}, 14'h0000, BAND_MAX); // R19
            end
        end
    end

    // AXI4-Lite read side
    assign ARREADY = !RVALID;

    always_ff @(posedge CLK) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA  <= '0;
            RRESP  <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP  <= RESP_OKAY;
            case (ARADDR)
                ADDR_CTRL:   RDATA <= {26'h0, ctrl};
                ADDR_DELAY:  RDATA <= {4'h0, off_delay, 4'h0, on_delay};
                ADDR_WATCH:  RDATA <= {18'h0, watch_time};
                ADDR_BAND:   RDATA <= {18'h0, stall_detect_band};
                ADDR_STATUS: RDATA <= {12'h0, 2'(dstate), watch_count,
                                       loop_stall_alarm, alarm_active, CONTACT, INDICATOR};
                ADDR_LIMITS: RDATA <= {4'h0, delay_count, 16'h0};
                default: begin
                    RDATA <= '0;
                    RRESP <= RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // Loop stall detection
    assign at_full     = LOOP.manipulated_output >= OUT_FULL;
    assign at_zero     = LOOP.manipulated_output == OUT_ZERO;
    assign input_fault = LOOP.sensor_break || LOOP.input_over_range || LOOP.input_under_range;
    assign suppress    = LOOP.auto_tune || LOOP.manual || !LOOP.running || LOOP.ramping; // R10
    assign zero_cfg    = watch_time == '0 || stall_detect_band == '0;
    assign rose        = {1'b0, LOOP.process_value} >=
                         {1'b0, pv_start} + {1'b0, stall_detect_band};
    assign fell        = {1'b0, pv_start} >=
                         {1'b0, LOOP.process_value} + {1'b0, stall_detect_band};
    assign restart_clear = ctrl[CTRL_INIT] || (ctrl[CTRL_COOL] != cool_prev) || zero_cfg; // R11
    assign restart_keep  = EVENTS.correction_change || EVENTS.set_value_change ||
                           ALARM_RESET; // R12 R15
    assign restart_std   = (LOOP.manipulated_output != out_prev) ||
                           (running_prev && !LOOP.running) ||
                           (LOOP.auto_tune && !tune_prev); // R13 R21

    always_ff @(posedge CLK) begin
        if (RST) begin
            out_prev     <= '0;
            running_prev <= 1'b0;
            tune_prev    <= 1'b0;
            cool_prev    <= 1'b0;
        end else begin
            out_prev     <= LOOP.manipulated_output;
            running_prev <= LOOP.running;
            tune_prev    <= LOOP.auto_tune;
            cool_prev    <= ctrl[CTRL_COOL];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || !ctrl[CTRL_STALL]) begin
            loop_stall_alarm <= 1'b0; // R16
            watch_count      <= '0;
            pv_start         <= '0;
        end else if (input_fault) begin
            loop_stall_alarm <= 1'b1; // R14
        end else if (restart_clear) begin
            loop_stall_alarm <= 1'b0; // R11
            watch_count      <= '0;
            pv_start         <= LOOP.process_value;
        end else if (restart_keep || restart_std || suppress || !(at_full || at_zero)) begin
            watch_count <= '0; // R12 R21
            pv_start    <= LOOP.process_value;
            if (restart_std && !ctrl[CTRL_LATCH]) begin
                loop_stall_alarm <= 1'b0; // R13
            end
        end else if (tick_sec) begin
            if (watch_count + 14'h1 >= watch_time) begin
                watch_count <= '0;
                pv_start    <= LOOP.process_value;
                if ((at_full != ctrl[CTRL_COOL]) ? !rose : !fell) begin
                    loop_stall_alarm <= 1'b1; // R8 R9
                end else if (!ctrl[CTRL_LATCH]) begin
                    loop_stall_alarm <= 1'b0; // R22
                end
            end else begin
                watch_count <= watch_count + 14'h1;
            end
        end
    end

    // On and off delay of the alarm output
    assign trigger = ctrl[CTRL_STALL] ? loop_stall_alarm : LOOP.trip;

    always_ff @(posedge CLK) begin
        if (RST) begin
            dstate       <= WAIT_IDLE;
            delay_count  <= '0;
            alarm_active <= 1'b0;
        end else begin
            case (dstate)
                WAIT_IDLE: begin
                    delay_count <= '0;
                    if (trigger && !alarm_active) begin
                        if (on_delay == '0) begin
                            alarm_active <= 1'b1;
                        end else begin
                            dstate <= WAIT_ON;
                        end
                    end else if (!trigger && alarm_active) begin
                        if (off_delay == '0) begin
                            alarm_active <= 1'b0;
                        end else begin
                            dstate <= WAIT_OFF;
                        end
                    end
                end
                WAIT_ON: begin
                    if (tick_sec) begin
                        delay_count <= delay_count + 12'h1;
                        if (delay_count + 12'h1 >= on_delay) begin
                            alarm_active <= trigger; // R5
                            dstate       <= WAIT_IDLE;
                        end
                    end
                end
                WAIT_OFF: begin
                    if (tick_sec) begin
                        delay_count <= delay_count + 12'h1;
                        if (delay_count + 12'h1 >= off_delay) begin
                            alarm_active <= trigger; // R6
                            dstate       <= WAIT_IDLE;
                        end
                    end
                end
                default: dstate <= WAIT_IDLE;
            endcase
        end
    end

    // Contact and indicator
    always_ff @(posedge CLK) begin
        if (RST) begin
            CONTACT   <= 1'b0;
            INDICATOR <= 1'b0;
        end else begin
            CONTACT <= alarm_active ^ ctrl[CTRL_NC]; // R1 R2
            if (dstate != WAIT_IDLE) begin
                INDICATOR <= flash; // R4
            end else begin
                INDICATOR <= alarm_active; // R3
            end
        end
    end

    hold_during_delay_a: assert property (@(posedge CLK) disable iff (RST) // R4
        dstate != WAIT_IDLE && $past(dstate) != WAIT_IDLE |-> $stable(alarm_active))
        else $error("Alarm changed while delay running");

    polarity_a: assert property (@(posedge CLK) disable iff (RST) // R1 R2
        !$past(RST) |-> CONTACT == ($past(alarm_active) ^ $past(ctrl[CTRL_NC])))
        else $error("Contact does not follow alarm and polarity");

    indicator_a: assert property (@(posedge CLK) disable iff (RST) // R3
        $past(dstate) == WAIT_IDLE |-> INDICATOR == $past(alarm_active))
        else $error("Indicator does not show alarm");

    fault_forces_a: assert property (@(posedge CLK) disable iff (RST) // R14
        ctrl[CTRL_STALL] && input_fault |=> loop_stall_alarm)
        else $error("Input fault did not raise stall alarm");

    stall_enable_a: assert property (@(posedge CLK) disable iff (RST) // R16
        !ctrl[CTRL_STALL] |=> !loop_stall_alarm)
        else $error("Stall alarm set while disabled");

    init_clear_a: assert property (@(posedge CLK) disable iff (RST) // R11
        ctrl[CTRL_STALL] && !input_fault && restart_clear
        |=> !loop_stall_alarm && watch_count == 0)
        else $error("Restart did not clear stall alarm");

    delay_limit_a: assert property (@(posedge CLK) disable iff (RST) // R7
        on_delay <= DELAY_MAX && off_delay <= DELAY_MAX)
        else $error("Delay setting above range");

    watch_limit_a: assert property (@(posedge CLK) disable iff (RST) // R18
        $rose(EVENTS.tune_done) && !EVENTS.input_type_change |=> watch_time >= WATCH_AUTO_MIN)
        else $error("Auto watch time below floor");

    band_limit_a: assert property (@(posedge CLK) disable iff (RST) // R19
        EVENTS.tune_done && !EVENTS.input_type_change |=> stall_detect_band <= BAND_AUTO_MAX)
        else $error("Auto band above ceiling");

    keep_state_a: assert property (@(posedge CLK) disable iff (RST) // R12
        ctrl[CTRL_STALL] && EVENTS.set_value_change && !input_fault && !restart_clear
        && !restart_std |=> $stable(loop_stall_alarm) && watch_count == 0)
        else $error("Set value change altered stall alarm");

endmodule // alarm_output

// *** alarm_pkg.sv ***
// Purpose: Constants, register map and types of the alarm output and loop stall block
// Assumes: 100 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   Values are process units scaled by ten (one decimal place)
package alarm_pkg;

    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SEC_CYCLES    = CLK_HZ;
    localparam int unsigned HALF_CYCLES   = CLK_HZ / 2;

    localparam logic [11:0] DELAY_MAX     = 12'he10;   // 3600 s
    localparam logic [13:0] WATCH_MAX     = 14'h270f;  // 9999 s
    localparam logic [13:0] WATCH_AUTO_MIN = 14'h0014; // 20 s
    localparam logic [13:0] BAND_MAX      = 14'h270f;  // 999.9
    localparam logic [13:0] BAND_AUTO_MIN = 14'h0014;  // 2.0
    localparam logic [13:0] BAND_AUTO_MAX = 14'h03e8;  // 100.0
    localparam logic [13:0] BAND_RESET    = 14'h0014;  // 2.0
    localparam logic [9:0]  OUT_FULL      = 10'h3e8;   // 100.0 %
    localparam logic [9:0]  OUT_ZERO      = 10'h000;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DELAY  = 8'h04;
    localparam logic [7:0] ADDR_WATCH  = 8'h08;
    localparam logic [7:0] ADDR_BAND   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_LIMITS = 8'h14;

    localparam int CTRL_NC      = 0;
    localparam int CTRL_LATCH   = 1;
    localparam int CTRL_COOL    = 2;
    localparam int CTRL_STALL   = 3;
    localparam int CTRL_INIT    = 4;
    localparam int DELAY_OFF_LSB = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WAIT_IDLE  = 2'b00,
        WAIT_ON    = 2'b01,
        WAIT_OFF   = 2'b10
    } delay_state_t;

    typedef struct packed {
        logic [13:0] process_value;
        logic [9:0]  manipulated_output;
        logic        running;
        logic        auto_tune;
        logic        manual;
        logic        ramping;
        logic        sensor_break;
        logic        input_over_range;
        logic        input_under_range;
        logic        trip;
    } loop_status_t;

    typedef struct packed {
        logic        set_value_change;
        logic        correction_change;
        logic        input_type_change;
        logic        tune_done;
        logic [13:0] tuned_integral;
        logic [13:0] tuned_band;
    } loop_event_t;

endpackage

// *** loop_core_model.sv ***
// Purpose: Control loop core model driving loop status and event pulses
// Assumes: Changes land right after a rising CLK edge
// Notes:   Events are one-cycle pulses as the block expects
module loop_core_model
    import alarm_pkg::*;
(
    input  wire logic    CLK,
    output loop_status_t LOOP,
    output loop_event_t  EVENTS
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        LOOP   = '0;
        EVENTS = '0;
    end

    // Level inputs change right after an edge
    task automatic set_status(input loop_status_t st);
        @(posedge CLK);
        LOOP <= st;
    endtask

    // One-cycle event pulse
    task automatic pulse_event(input loop_event_t ev);
        @(posedge CLK);
        EVENTS <= ev;
        @(posedge CLK);
        EVENTS <= '0;
    endtask
endmodule // loop_core_model

// *** alarm_output_tb_top.sv ***
// Purpose: Self-checking bench of the alarm output block
// Assumes: Second-based counts too long to simulate; delays seen only while running
// Notes:   Registers reached over AXI4-Lite
module alarm_output_tb_top
    import alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         alarm_reset = 1'b0;
    logic         contact, indicator, awready, wready, bvalid, arready, rvalid;
    logic [7:0]   awaddr = '0, araddr = '0;
    logic [31:0]  wdata = '0, rdata, rd;
    logic [3:0]   wstrb = '0;
    logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0]   bresp, rresp, rs;
    loop_status_t loop, st;
    loop_event_t  events, ev;
    int           n_errors = 0;
    int           comparisons = 0;

    always #5 clk = ~clk;

    loop_core_model u_loop (.CLK(clk), .LOOP(loop), .EVENTS(events));

    alarm_output u_dut (.CLK(clk), .RST(rst), .LOOP(loop), .EVENTS(events),
        .ALARM_RESET(alarm_reset), .CONTACT(contact), .INDICATOR(indicator),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Each channel held until its own ready is seen at an edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic an;
        logic wn;
        logic bn;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge clk);
            an = awready;
            wn = wready;
            bn = bvalid === 1'b1;
            r  = bresp;
            @(posedge clk);
            if (an) awvalid <= 1'b0;
            if (wn) wvalid <= 1'b0;
        end while (!bn);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic an;
        logic rn;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge clk);
            an = arready;
            rn = rvalid === 1'b1;
            d  = rdata;
            r  = rresp;
            @(posedge clk);
            if (an) arvalid <= 1'b0;
        end while (!rn);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        axi_write(a, d, rs);
        check("write response", {30'h0, er}, {30'h0, rs});
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        axi_read(a, rd, rs);
        check(n, e, rd);
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic test_reset_values;
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("delay", ADDR_DELAY, 32'h0);
        rd_chk("watch", ADDR_WATCH, 32'h0);
        rd_chk("band", ADDR_BAND, 32'h14);
        @(negedge clk);
        check("contact", 32'h0, {31'h0, contact});
    endtask

    task automatic test_reg_limits;
        wr(ADDR_DELAY, 32'hffff_ffff, RESP_OKAY);
        rd_chk("delay max", ADDR_DELAY, 32'h0e10_0e10);
        wr(ADDR_WATCH, 32'h3fff, RESP_OKAY);
        rd_chk("watch max", ADDR_WATCH, 32'h270f);
        wr(ADDR_BAND, 32'h3fff, RESP_OKAY);
        rd_chk("band max", ADDR_BAND, 32'h270f);
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
        rd_chk("unmapped", 8'h40, 32'h0);
        check("read response", {30'h0, RESP_SLVERR}, {30'h0, rs});
        wr(ADDR_DELAY, 32'h0, RESP_OKAY);
    endtask

    task automatic test_polarity;
        logic [1:0] i;
        for (i = 0; i < 2'h2; i++) begin
            wr(ADDR_CTRL, {31'h0, i[0]}, RESP_OKAY);
            st.trip = 1'b0;
            u_loop.set_status(st);
            settle();
            check("contact idle", {31'h0, i[0]}, {31'h0, contact});
            check("indicator idle", 32'h0, {31'h0, indicator});
            st.trip = 1'b1;
            u_loop.set_status(st);
            settle();
            check("contact alarm", {31'h0, ~i[0]}, {31'h0, contact});
            check("indicator alarm", 32'h1, {31'h0, indicator});
        end
        st.trip = 1'b0;
        u_loop.set_status(st);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    endtask

    task automatic tune(input logic [13:0] ti, input logic [13:0] tb,
                        input logic [31:0] ew, input logic [31:0] eb);
        ev = '0;
        ev.tune_done = 1'b1;
        ev.tuned_integral = ti;
        ev.tuned_band = tb;
        u_loop.pulse_event(ev);
        settle();
        rd_chk("auto watch", ADDR_WATCH, ew);
        rd_chk("auto band", ADDR_BAND, eb);
    endtask

    task automatic test_tune;
        tune(14'h5, 14'h1, 32'h14, 32'h14);
        tune(14'h64, 14'h100, 32'hc8, 32'h100);
        ev = '0;
        ev.input_type_change = 1'b1;
        u_loop.pulse_event(ev);
        settle();
        rd_chk("watch on type change", ADDR_WATCH, 32'h0);
        rd_chk("band on type change", ADDR_BAND, 32'h14);
        tune(14'h1770, 14'h7d0, 32'h270f, 32'h3e8);
    endtask

    task automatic test_faults;
        int i;
        for (i = 0; i < 4; i++) begin
            wr(ADDR_CTRL, (i == 3) ? 32'h0a : (i == 1) ? 32'h0c : 32'h08, RESP_OKAY);
            st.sensor_break = (i == 0 || i == 3);
            st.input_over_range = (i == 1);
            st.input_under_range = (i == 2);
            u_loop.set_status(st);
            settle();
            check("contact", 32'h1, {31'h0, contact});
            rd_chk("stall on fault", ADDR_STATUS, 32'hf);
            check("stall bit", 32'h1, {31'h0, rd[3]});
            st.sensor_break = 1'b0;
            st.input_over_range = 1'b0;
            st.input_under_range = 1'b0;
            if (i != 0) st.manipulated_output = st.manipulated_output + 10'h1;
            if (i == 2) st.running = 1'b0;
            u_loop.set_status(st);
            ev = '0;
            ev.set_value_change = 1'b1;
            u_loop.pulse_event(ev);
            alarm_reset <= 1'b1;
            @(posedge clk);
            alarm_reset <= 1'b0;
            settle();
            axi_read(ADDR_STATUS, rd, rs);
            check("stall kept", (i == 0 || i == 3) ? 32'h1 : 32'h0, {31'h0, rd[3]});
            wr(ADDR_CTRL, 32'h18, RESP_OKAY);
            settle();
            axi_read(ADDR_STATUS, rd, rs);
            check("stall after init", 32'h0, {31'h0, rd[3]});
            st.running = 1'b1;
        end
    endtask

    task automatic test_delay;
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wr(ADDR_DELAY, 32'h1, RESP_OKAY);
        st.trip = 1'b1;
        u_loop.set_status(st);
        settle();
        check("contact held", 32'h0, {31'h0, contact});
        rd_chk("on delay running", ADDR_STATUS, 32'h0004_0000);
        rd_chk("delay count", ADDR_LIMITS, 32'h0);
        st.trip = 1'b0;
        u_loop.set_status(st);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("status after reset", ADDR_STATUS, 32'h0);
        rd_chk("delay after reset", ADDR_DELAY, 32'h0);
    endtask

    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    initial begin
        st = '0;
        st.running = 1'b1;
        st.manipulated_output = 10'h1f4;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        u_loop.set_status(st);
        test_reset_values();
        test_reg_limits();
        test_polarity();
        test_tune();
        test_faults();
        test_delay();
        give_verdict();
    end
endmodule // alarm_output_tb_top
